// file: design/byte_skid_buffer.sv
/*
 * Two-entry valid/ready buffer in the reply byte path.
 * Assumes a single clock, asynchronous active-high reset.
 */
`timescale 1ns/1ns
module byte_skid_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	logic [WIDTH-1:0] mem_reg [2];
	logic             wr_ptr_reg;
	logic             rd_ptr_reg;
	logic [1:0]       count_reg;
	logic             push;
	logic             pop;

	// Full and empty come straight from the count, so ready never lies
	assign push        = in_valid_i && (count_reg != 2'h2);
	assign pop         = out_valid_o && out_ready_i;
	assign in_ready_o  = (count_reg != 2'h2);
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o  = mem_reg[rd_ptr_reg];

	// Storage write side
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wr_ptr_reg <= 1'b0;
		end else if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
			wr_ptr_reg          <= ~wr_ptr_reg;
		end
	end

	// Read pointer and occupancy
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	chk_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
		count_reg <= 2'h2) else $error("buffer count above two");
endmodule // byte_skid_buffer

// file: design/cmd_frame_defs.svh
/*
 * Constants for the serial command frame engine: frame layout, status codes
 * and reset values.
 * Assumes inclusion by bare name from the design module and the bench.
 */
// Behaviour
// - Byte link command frame: address, command, type, selector, four value bytes, checksum.
// - Core is command, type, selector bytes and a value sent MSB first.
// - Command checksum is modulo-256 sum of the eight preceding bytes.
// - Every accepted command gets reply: reply addr, module addr, status, command, value, sum.
// - Reply checksum is the 8-bit wrapping sum of all other reply bytes.
// - Status is one of 100, 101, 1, 2, 3, 4, 5, 6.
// - Transmit only as a reply; stay receiving otherwise, never unsolicited.
// - Reply is sent only after the command's actions have completed.
// - Packet variant commands carry no address and no checksum byte.
// - Packet variant replies carry no address and no checksum byte.
`ifndef CMD_FRAME_DEFS_SVH
`define CMD_FRAME_DEFS_SVH

`define CFE_BYTE_FRAME_LEN   4'h9
`define CFE_CORE_FRAME_LEN   4'h7
`define CFE_VALUE_BYTES      4'h4
`define CFE_BYTE_REPLY_LEN   4'h9
`define CFE_PKT_REPLY_LEN    4'h6

`define CFE_ST_OK            8'h64
`define CFE_ST_STORED        8'h65
`define CFE_ST_BAD_SUM       8'h01
`define CFE_ST_BAD_CMD       8'h02
`define CFE_ST_BAD_TYPE      8'h03
`define CFE_ST_BAD_VALUE     8'h04
`define CFE_ST_LOCKED        8'h05
`define CFE_ST_UNAVAIL       8'h06

`define CFE_RST_BYTE         8'h00
`define CFE_RST_COUNT        4'h0

`endif

// file: design/cmd_frame_pkg.sv
/*
 * Types for the serial command frame engine.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cmd_frame_pkg;

	// Decoded command core handed to the executor
	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  kind;
		logic [7:0]  selector;
		logic [31:0] value;
	} cmd_core_t;

	// Executor result that fills the reply
	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] value;
	} exec_result_t;

	// Engine states, Gray coded along receive, execute, reply
	typedef enum logic [1:0] {
		ST_RECV  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_REPLY = 2'b11
	} engine_state_t;

endpackage

// file: design/serial_command_frame_engine.sv
/*
 * Serial command frame engine: collects command bytes, checks the sum,
 * hands the core to an executor, and returns the reply frame.
 * Assumes bytes arrive from a same-clock UART or packet receiver as
 * one-cycle strobes and the executor answers with a one-cycle done.
 */
`timescale 1ns/1ns
`include "cmd_frame_defs.svh"
module serial_command_frame_engine (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        packet_mode_i,
	input  wire logic [7:0]                  module_addr_i,
	input  wire logic [7:0]                  reply_addr_i,
	input  wire logic [7:0]                  rx_data_i,
	input  wire logic                        rx_valid_i,
	input  wire logic                        rx_frame_start_i,
	output logic                             exec_start_o,
	output cmd_frame_pkg::cmd_core_t         exec_cmd_o,
	input  wire logic                        exec_done_i,
	input  wire cmd_frame_pkg::exec_result_t exec_result_i,
	output logic [7:0]                       tx_data_o,
	output logic                             tx_valid_o,
	input  wire logic                        tx_ready_i,
	output logic                             tx_enable_o,
	output logic                             bad_sum_o
);
	cmd_frame_pkg::engine_state_t state_reg;
	logic [7:0]                   frame_reg [9];
	logic [3:0]                   rx_cnt_reg;
	logic [7:0]                   rx_sum_reg;
	logic [3:0]                   tx_cnt_reg;
	logic [7:0]                   tx_sum_reg;
	logic [7:0]                   rep_reg [9];
	logic                         exec_start_reg;
	logic                         bad_sum_reg;
	logic                         tx_enable_reg;
	logic [3:0]                   frame_len;
	logic [3:0]                   reply_last;
	logic [7:0]                   frame_next [9];
	cmd_frame_pkg::cmd_core_t     exec_cmd_reg;
	logic [3:0]                   core_base;
	logic                         frame_done;
	logic                         addr_ok;
	logic                         sum_ok;
	logic                         buf_ready;
	logic [7:0]                   tx_byte;
	logic                         tx_push;
	logic [7:0]                   buf_data;
	logic                         buf_valid;
	logic [7:0]                   tx_data_reg;
	logic                         tx_valid_reg;
	logic                         out_take;

	// Length and core offset depend on transport
	assign frame_len  = packet_mode_i ? `CFE_CORE_FRAME_LEN : `CFE_BYTE_FRAME_LEN;
	assign core_base  = packet_mode_i ? 4'h0 : 4'h1;
	// Packet replies lose both address bytes and the sum, so they are shorter
	assign reply_last = packet_mode_i ? (`CFE_PKT_REPLY_LEN - 4'h1)
		: (`CFE_BYTE_REPLY_LEN - 4'h1);
	assign frame_done = rx_valid_i && (state_reg == cmd_frame_pkg::ST_RECV)
		&& (rx_cnt_reg == frame_len - 4'h1);
	// Packet variant addressing is done by the identifier filter upstream
	assign addr_ok    = packet_mode_i || (frame_reg[0] == module_addr_i);
	assign sum_ok     = packet_mode_i || (rx_sum_reg == rx_data_i);

	// Byte collection and running sum over the first eight bytes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_cnt_reg <= `CFE_RST_COUNT;
			rx_sum_reg <= `CFE_RST_BYTE;
			for (int i = 0; i < 9; i++)
				frame_reg[i] <= `CFE_RST_BYTE;
		end else if (state_reg != cmd_frame_pkg::ST_RECV) begin
			rx_cnt_reg <= `CFE_RST_COUNT; // Bytes during a command are dropped
			rx_sum_reg <= `CFE_RST_BYTE;
		end else if (rx_frame_start_i && !rx_valid_i) begin
			rx_cnt_reg <= `CFE_RST_COUNT; // Resync on idle gap
			rx_sum_reg <= `CFE_RST_BYTE;
		end else if (rx_valid_i) begin
			frame_reg[rx_cnt_reg] <= rx_data_i;
			rx_sum_reg <= frame_done ? `CFE_RST_BYTE : rx_sum_reg + rx_data_i;
			rx_cnt_reg <= frame_done ? `CFE_RST_COUNT : rx_cnt_reg + 4'h1;
		end
	end

	// Frame image with this cycle's byte folded in; packet frames end on a core byte
	for (genvar g = 0; g < 9; g++) begin : g_frame_next
		assign frame_next[g] = (rx_valid_i && rx_cnt_reg == 4'(g)) ? rx_data_i : frame_reg[g];
	end

	// Core latched on acceptance, value MSB first; stands until the next good frame
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			exec_cmd_reg <= '0;
		end else if (frame_done && addr_ok && sum_ok) begin
			exec_cmd_reg.opcode   <= frame_next[core_base];
			exec_cmd_reg.kind     <= frame_next[core_base + 4'h1];
			exec_cmd_reg.selector <= frame_next[core_base + 4'h2];
			exec_cmd_reg.value    <= {frame_next[core_base + 4'h3], frame_next[core_base + 4'h4],
				frame_next[core_base + 4'h5], frame_next[core_base + 4'h6]};
		end
	end
	assign exec_cmd_o = exec_cmd_reg;

	// Sequencer; checksum failures skip the executor and reply at once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg      <= cmd_frame_pkg::ST_RECV;
			exec_start_reg <= 1'b0;
			bad_sum_reg    <= 1'b0;
		end else begin
			exec_start_reg <= 1'b0;
			unique case (state_reg)
				cmd_frame_pkg::ST_RECV: if (frame_done && addr_ok) begin
					bad_sum_reg <= !sum_ok;
					if (sum_ok) begin
						state_reg      <= cmd_frame_pkg::ST_EXEC;
						exec_start_reg <= 1'b1;
					end else begin
						state_reg <= cmd_frame_pkg::ST_REPLY;
					end
				end
				cmd_frame_pkg::ST_EXEC: if (exec_done_i)
					state_reg <= cmd_frame_pkg::ST_REPLY;
				cmd_frame_pkg::ST_REPLY: if (tx_push && tx_cnt_reg == reply_last)
					state_reg <= cmd_frame_pkg::ST_RECV;
			endcase
		end
	end
	assign exec_start_o = exec_start_reg;
	assign bad_sum_o    = bad_sum_reg;

	// Reply image captured on completion; byte frame adds addresses and sum
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 9; i++)
				rep_reg[i] <= `CFE_RST_BYTE;
		end else if ((state_reg == cmd_frame_pkg::ST_EXEC && exec_done_i)
				|| (state_reg == cmd_frame_pkg::ST_RECV && frame_done && addr_ok && !sum_ok)) begin
			rep_reg[0] <= reply_addr_i;
			rep_reg[1] <= module_addr_i;
			rep_reg[2] <= (state_reg == cmd_frame_pkg::ST_EXEC)
				? exec_result_i.status : `CFE_ST_BAD_SUM;
			rep_reg[3] <= (state_reg == cmd_frame_pkg::ST_EXEC)
				? exec_cmd_o.opcode : frame_reg[core_base];
			rep_reg[4] <= (state_reg == cmd_frame_pkg::ST_EXEC) ? exec_result_i.value[31:24] : 8'h00;
			rep_reg[5] <= (state_reg == cmd_frame_pkg::ST_EXEC) ? exec_result_i.value[23:16] : 8'h00;
			rep_reg[6] <= (state_reg == cmd_frame_pkg::ST_EXEC) ? exec_result_i.value[15:8] : 8'h00;
			rep_reg[7] <= (state_reg == cmd_frame_pkg::ST_EXEC) ? exec_result_i.value[7:0] : 8'h00;
		end
	end

	// Byte selection: packet variant skips both address bytes and the sum
	assign tx_byte = (!packet_mode_i && tx_cnt_reg == 4'h8) ? tx_sum_reg
		: rep_reg[packet_mode_i ? tx_cnt_reg + 4'h2 : tx_cnt_reg];
	assign tx_push = (state_reg == cmd_frame_pkg::ST_REPLY) && buf_ready;

	// Transmit index and running reply sum
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_cnt_reg <= `CFE_RST_COUNT;
			tx_sum_reg <= `CFE_RST_BYTE;
		end else if (tx_push) begin
			tx_sum_reg <= tx_sum_reg + tx_byte;
			tx_cnt_reg <= (tx_cnt_reg == reply_last) ? `CFE_RST_COUNT : tx_cnt_reg + 4'h1;
			if (tx_cnt_reg == reply_last)
				tx_sum_reg <= `CFE_RST_BYTE;
		end
	end

	byte_skid_buffer #(
		.WIDTH(8)
	) u_reply_buf (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.in_data_i  (tx_byte),
		.in_valid_i (tx_push),
		.in_ready_o (buf_ready),
		.out_data_o (buf_data),
		.out_valid_o(buf_valid),
		.out_ready_i(out_take)
	);

	// Registered output stage so tx ports come from flip-flops
	assign out_take = !tx_valid_reg || tx_ready_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_data_reg  <= `CFE_RST_BYTE;
			tx_valid_reg <= 1'b0;
		end else if (out_take) begin
			tx_data_reg  <= buf_data;
			tx_valid_reg <= buf_valid;
		end
	end

	// Driver enable only while a reply is in flight, released when drained
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			tx_enable_reg <= 1'b0;
		else
			tx_enable_reg <= (state_reg == cmd_frame_pkg::ST_REPLY) || buf_valid
				|| (tx_valid_reg && !tx_ready_i);
	end
	assign tx_data_o   = tx_data_reg;
	assign tx_valid_o  = tx_valid_reg;
	assign tx_enable_o = tx_enable_reg;

	chk_tx_only_reply: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_valid_o |-> tx_enable_o) else $error("byte out while driver off");
	chk_reply_after_exec: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == cmd_frame_pkg::ST_EXEC && !exec_done_i)
		|=> state_reg != cmd_frame_pkg::ST_REPLY)
		else $error("reply before completion");
	chk_exec_on_good: assert property (@(posedge clk_i) disable iff (rst_i)
		exec_start_o |-> $past(frame_done) && $past(sum_ok) && $past(addr_ok))
		else $error("executor started without a good frame");
	chk_foreign_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
		(frame_done && !addr_ok) |=> state_reg == cmd_frame_pkg::ST_RECV)
		else $error("foreign frame was answered");
	chk_bad_sum_status: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == cmd_frame_pkg::ST_RECV && frame_done && addr_ok && !sum_ok)
		|=> rep_reg[2] == `CFE_ST_BAD_SUM) else $error("wrong status on bad sum");
	chk_sum_byte: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_push && !packet_mode_i && tx_cnt_reg == 4'h8) |-> tx_byte ==
		8'(rep_reg[0] + rep_reg[1] + rep_reg[2] + rep_reg[3] + rep_reg[4] + rep_reg[5]
		+ rep_reg[6] + rep_reg[7])) else $error("reply checksum wrong");
	chk_packet_first: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_push && packet_mode_i && tx_cnt_reg == 4'h0) |-> tx_byte == rep_reg[2])
		else $error("packet reply carries address");
	chk_value_msb: assert property (@(posedge clk_i) disable iff (rst_i)
		exec_start_o |-> exec_cmd_o.value[31:24] == frame_reg[core_base + 4'h3])
		else $error("value byte order wrong");
	chk_core_held: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg != cmd_frame_pkg::ST_RECV) |=> $stable(exec_cmd_o))
		else $error("command core changed while busy");
	chk_rx_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_done |=> (rx_sum_reg == `CFE_RST_BYTE) && (rx_cnt_reg == `CFE_RST_COUNT))
		else $error("receive sum not cleared at frame end");
endmodule // serial_command_frame_engine

// file: tb/host_model.sv
/*
 * Host bus master model: builds command frames, sends them byte by byte,
 * and collects reply bytes. Assumes the bench calls send_cmd at a falling edge.
 */
`timescale 1ns/1ns
module host_model (
	input  wire logic       clk_i,
	input  wire logic       stall_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic      [7:0] rx_data_o,
	output logic            rx_valid_o,
	output logic            tx_ready_o
);
	logic [7:0] reply_q[$];

	initial begin
		rx_data_o = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b1;
	end

	// Toggling ready while stalling makes the reply buffer hold bytes
	always @(negedge clk_i) begin
		tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
	end

	// Reply bytes are taken on the handshake edge
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			reply_q.push_back(tx_data_i);
		end
	end

	// One frame; between strobes the line shows the inverse of the last byte.
	// Returns right after the last strobe so the caller sees the one-cycle answer
	task automatic send_cmd(input logic pk, input logic [7:0] addr, input logic [7:0] cmd,
		input logic [31:0] val, input logic [7:0] sum_err);
		logic [7:0] f[$];
		logic [7:0] sum;
		f = {cmd, 8'h5C, 8'hC3, val[31:24], val[23:16], val[15:8], val[7:0]};
		if (!pk) begin
			f.push_front(addr);
			sum = 8'h00;
			foreach (f[i]) begin
				sum += f[i];
			end
			f.push_back(sum ^ sum_err);
		end
		foreach (f[i]) begin
			rx_data_o = f[i];
			rx_valid_o = 1'b1;
			@(negedge clk_i);
			rx_valid_o = 1'b0;
			rx_data_o = ~f[i];
			if (i < f.size() - 1) begin
				@(negedge clk_i);
			end
		end
	endtask

	// Leading bytes of a frame only, as from a sender that stopped mid-frame
	task automatic send_stub(input logic [7:0] b, input int n);
		repeat (n) begin
			rx_data_o = b;
			rx_valid_o = 1'b1;
			@(negedge clk_i);
			rx_valid_o = 1'b0;
			rx_data_o = ~b;
			@(negedge clk_i);
		end
	endtask
endmodule // host_model

// file: tb/serial_command_frame_engine_tb.sv
/*
 * Self-checking bench for the command frame engine; the bench plays the executor.
 * Assumes the host model on the serial side and a 25 MHz clock.
 */
`timescale 1ns/1ns
`include "cmd_frame_defs.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("wrong value %s expected %h seen %h", what, exp, got); end end
module serial_command_frame_engine_tb;
	logic                       clk_i, rst_i, packet_mode_i, rx_frame_start_i;
	logic [7:0]                 module_addr_i, reply_addr_i, rx_data_i, tx_data_o;
	logic                       rx_valid_i, exec_start_o, exec_done_i, tx_valid_o;
	logic                       tx_ready_i, tx_enable_o, bad_sum_o, stall, act_seen;
	cmd_frame_pkg::cmd_core_t   exec_cmd_o;
	cmd_frame_pkg::exec_result_t exec_result_i;
	int                         bad_count, num_checks, cycles;
	logic [7:0]                 codes [7] = '{`CFE_ST_OK, `CFE_ST_STORED, `CFE_ST_BAD_CMD,
		`CFE_ST_BAD_TYPE, `CFE_ST_BAD_VALUE, `CFE_ST_LOCKED, `CFE_ST_UNAVAIL};

	serial_command_frame_engine u_serial_command_frame_engine (.clk_i(clk_i), .rst_i(rst_i),
		.packet_mode_i(packet_mode_i), .module_addr_i(module_addr_i),
		.reply_addr_i(reply_addr_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
		.rx_frame_start_i(rx_frame_start_i), .exec_start_o(exec_start_o),
		.exec_cmd_o(exec_cmd_o), .exec_done_i(exec_done_i), .exec_result_i(exec_result_i),
		.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
		.tx_enable_o(tx_enable_o), .bad_sum_o(bad_sum_o));
	host_model u_host_model (.clk_i(clk_i), .stall_i(stall), .tx_data_i(tx_data_o),
		.tx_valid_i(tx_valid_o), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
		.tx_ready_o(tx_ready_i));

	// Clock, hang guard, and a flag for any unprompted activity
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (exec_start_o === 1'b1 || tx_enable_o === 1'b1) begin
			act_seen = 1'b1;
		end
		if (cycles == 8000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (bad_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Idle after reset, then a frame for another node: nothing may answer
	task automatic foreign_frame();
		act_seen = 1'b0;
		repeat (20) @(negedge clk_i);
		`CHK("idle activity", 1'b0, act_seen)
		u_host_model.send_cmd(1'b0, 8'h33, 8'h06, 32'h0, 8'h00);
		repeat (40) @(negedge clk_i);
		`CHK("foreign activity", 1'b0, act_seen)
	endtask

	// One command and its reply; a nonzero sum_err corrupts the checksum
	task automatic run_cmd(input logic pk, input logic [7:0] cmd, input logic [31:0] val,
		input logic [7:0] sum_err, input logic [7:0] st);
		logic [7:0] exp[$];
		logic [7:0] s;
		int n;
		u_host_model.reply_q.delete();
		packet_mode_i = pk;
		u_host_model.send_cmd(pk, 8'h2A, cmd, val, sum_err);
		if (sum_err == 8'h00) begin
			n = 0;
			while (exec_start_o !== 1'b1 && n < 20) begin
				@(negedge clk_i);
				n++;
			end
			`CHK("exec start", 1'b1, exec_start_o)
			`CHK("core", {cmd, 8'h5C, 8'hC3, val}, exec_cmd_o)
			// The executor is slow on purpose: no reply may start meanwhile
			repeat (6) begin
				@(negedge clk_i);
				`CHK("early tx", 3'b000, {tx_valid_o, tx_enable_o, exec_start_o})
			end
			exec_result_i = {st, ~val};
			exec_done_i = 1'b1;
			@(negedge clk_i);
			exec_done_i = 1'b0;
			val = ~val;
		end else begin
			st = `CFE_ST_BAD_SUM;
			val = 32'h0;
		end
		exp = {st, cmd, val[31:24], val[23:16], val[15:8], val[7:0]};
		if (!pk) begin
			exp.push_front(8'h2A);
			exp.push_front(8'h02);
			s = 8'h00;
			foreach (exp[i]) begin
				s += exp[i];
			end
			exp.push_back(s);
		end
		n = 0;
		while (u_host_model.reply_q.size() < exp.size() && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		repeat (8) @(negedge clk_i);
		`CHK("reply length", exp.size(), u_host_model.reply_q.size())
		foreach (exp[i]) begin
			`CHK("reply byte", exp[i], u_host_model.reply_q[i])
		end
		`CHK("line released", 1'b0, tx_enable_o)
		if (!pk) begin
			`CHK("sum flag", sum_err != 8'h00, bad_sum_o)
		end
	endtask

	// A cut frame is abandoned on the gap pulse; the next command must still land
	task automatic resync_cut();
		u_host_model.send_stub(8'h2A, 4);
		rx_frame_start_i = 1'b1;
		@(negedge clk_i);
		rx_frame_start_i = 1'b0;
		run_cmd(1'b0, 8'h0A, 32'h0000_00A5, 8'h00, `CFE_ST_OK);
	endtask

	// Reset lands while a reply drains: outputs drop at once and stay low after release
	task automatic reset_mid_reply();
		u_host_model.send_cmd(1'b0, 8'h2A, 8'h0C, 32'h0, 8'h01);
		repeat (4) @(negedge clk_i);
		`CHK("reply running", 1'b1, tx_enable_o)
		rst_i = 1'b1;
		@(negedge clk_i);
		`CHK("in reset", 4'h0, {tx_valid_o, tx_enable_o, exec_start_o, bad_sum_o})
		rst_i = 1'b0;
		@(negedge clk_i);
		`CHK("after reset", 4'h0, {tx_valid_o, tx_enable_o, exec_start_o, bad_sum_o})
		run_cmd(1'b0, 8'h0D, 32'h0000_5A5A, 8'h00, `CFE_ST_OK);
	endtask

	// Each command waits for the whole previous reply, except 0x0D, sent after reset cuts the 0x0C reply short
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		packet_mode_i = 1'b0;
		module_addr_i = 8'h2A;
		reply_addr_i = 8'h02;
		rx_frame_start_i = 1'b0;
		exec_done_i = 1'b0;
		exec_result_i = '0;
		stall = 1'b0;
		act_seen = 1'b0;
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		foreign_frame();
		// A clean frame right after a dropped one catches a stale running sum
		foreach (codes[i]) begin
			run_cmd(1'b0, 8'(i + 1), 32'h8000_0001 << i, 8'h00, codes[i]);
		end
		run_cmd(1'b0, 8'hFF, 32'hFFFF_FF80, 8'h01, 8'h00);
		resync_cut();
		reset_mid_reply();
		stall = 1'b1;
		run_cmd(1'b1, 8'h05, 32'h1234_5678, 8'h00, `CFE_ST_OK);
		stall = 1'b0;
		conclude();
	end
endmodule // serial_command_frame_engine_tb
